// ---- rtl/dssi_pkg.sv ----
package dssi_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int REG_W = 16;
	localparam int ADDR_W = 16;
	localparam logic [15:0] ADDR_PLL_FB_DIV = 16'hF000;
	localparam logic [15:0] ADDR_PLL_IN_DIV = 16'hF001;
	localparam logic [15:0] ADDR_CORE_CLK_SRC = 16'hF002;
	localparam logic [15:0] ADDR_PLL_RUN = 16'hF003;
	localparam logic [15:0] ADDR_PLL_LOCK = 16'hF004;
	localparam logic [15:0] ADDR_CLK_OUT = 16'hF005;
	localparam logic [15:0] ADDR_MAIN_PWR = 16'hF050;
	localparam logic [15:0] ADDR_AUX_PWR = 16'hF051;
	localparam logic [15:0] ADDR_SLEEP = 16'hF400;
	localparam logic [15:0] ADDR_PULSE_SEL = 16'hF401;
	localparam logic [15:0] ADDR_LAUNCH = 16'hF402;
	localparam logic [15:0] ADDR_HALT = 16'hF403;
	localparam logic [15:0] ADDR_ENTRY = 16'hF404;
	localparam logic [15:0] ADDR_RESTART = 16'hF890;

	// ----------------------------------------
	// Reset values and field codes
	// ----------------------------------------
	localparam logic [15:0] RST_PLL_FB_DIV = 16'h0060;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_RESTART = 16'h0001;
	localparam logic [15:0] PULSE_INTERNAL = 16'h0002;
	localparam int BIT_EN = 0;
	localparam int CLKOUT_RATE_LSB = 1;
	localparam int CLKOUT_RATE_MSB = 2;
	localparam int PREDIV_MSB = 1;
	localparam int SPI_TOGGLES = 3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_FREQ_MHZ = 100;
	localparam int SOFT_WAIT_NS = 650;
	localparam int SOFT_WAIT_CYC = (SOFT_WAIT_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int LOCK_TIME_US = 10666;
	localparam int LOCK_CYC = LOCK_TIME_US * CLK_FREQ_MHZ;
	localparam int LOCK_CNT_W = 21;
	localparam int FRAME_RATE_HZ = 48000;
	localparam int FRAME_CYC = CLK_FREQ_MHZ * 1000000 / FRAME_RATE_HZ;
	localparam int FRAME_CNT_W = 12;
	localparam int WAIT_CNT_W = 8;

	typedef enum logic {CORE_STOPPED, CORE_RUNNING} dssi_core_t;

endpackage : dssi_pkg

// ---- rtl/dssi_pll_lock.sv ----
`timescale 1ns/1ps
`default_nettype none
module dssi_pll_lock
	import dssi_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_CYC
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic start,
	input wire logic stop,
	output logic locking,
	output logic locked
);

	logic [LOCK_CNT_W-1:0] cnt_reg;

	// Lock attempt timer
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
			locking <= 1'b0;
			locked <= 1'b0;
		end else if (stop) begin
			locking <= 1'b0;
			locked <= 1'b0;
		end else if (start) begin
			cnt_reg <= '0;
			locking <= 1'b1;
			locked <= 1'b0;
		end else if (locking) begin
			if (cnt_reg == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
				locking <= 1'b0;
				locked <= 1'b1;
			end
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

endmodule : dssi_pll_lock
`default_nettype wire

// ---- rtl/dssi_spi_entry.sv ----
`timescale 1ns/1ps
`default_nettype none
module dssi_spi_entry
	import dssi_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic select_or_addr_pin,
	output logic spi_mode
);

	logic pin_prev_reg;
	logic [1:0] rise_cnt_reg;
	logic rise;

	assign rise = select_or_addr_pin & ~pin_prev_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pin_prev_reg <= 1'b1;
		end else begin
			pin_prev_reg <= select_or_addr_pin;
		end
	end

	// Counting low-to-high toggles
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rise_cnt_reg <= 2'h0;
			spi_mode <= 1'b0;
		end else if (rise && !spi_mode) begin
			if (rise_cnt_reg == 2'(SPI_TOGGLES - 1)) begin
				spi_mode <= 1'b1;
			end
			rise_cnt_reg <= rise_cnt_reg + 2'h1;
		end
	end

endmodule : dssi_spi_entry
`default_nettype wire

// ---- rtl/dssi_startup.sv ----
// Overview of operation
// - Three low-high toggles of the select pin switch the port to SPI.
// - Restart 0 enters soft reset, 1 exits; then 650 ns before accesses.
// - Halt write of 1 stops the core; core_running falls 2 cycles after the write.
// - Feedback divider defaults to 96; host sets it before PLL run.
// - Input divider code 2 divides the master clock by 4.
// - Clock source 1 runs the core from the PLL output.
// - Clock output value 5 enables the clock output pin.
// - Main power gating 0x4FFF powers all but clock generator 3.
// - Aux power gating 0 powers down mic, S/PDIF and aux ADC.
// - Entry point register sets where execution begins at launch.
// - Pulse select 2 triggers each run from an internal frame pulse.
// - Core cannot start until the halt is released with 0.
// - Core starts on a low-to-high transition of the launch register.
// - Lock status bit 0 rises when the PLL has locked.
// - While the PLL locks the control port is inactive; writes fail.
`timescale 1ns/1ps
`default_nettype none
module dssi_startup
	import dssi_pkg::*;
#(
	parameter int LOCK_CYCLES = dssi_pkg::LOCK_CYC
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic select_or_addr_pin,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [dssi_pkg::ADDR_W-1:0] addr,
	input wire logic [dssi_pkg::REG_W-1:0] wdata,
	input wire logic ext_frame_pulse,
	output logic [dssi_pkg::REG_W-1:0] rdata,
	output logic rd_valid,
	output logic acc_fail,
	output logic spi_mode,
	output logic pll_locked,
	output logic soft_reset_active,
	output logic hibernate,
	output logic core_running,
	output logic core_frame_start,
	output logic [dssi_pkg::REG_W-1:0] core_pc,
	output logic [dssi_pkg::REG_W-1:0] pll_mult,
	output logic [3:0] pll_prediv,
	output logic core_clk_from_pll,
	output logic clkout_en,
	output logic [1:0] clkout_rate,
	output logic [dssi_pkg::REG_W-1:0] main_power,
	output logic [dssi_pkg::REG_W-1:0] aux_power
);
	import dssi_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [REG_W-1:0] pll_feedback_divider_reg;
	logic [REG_W-1:0] pll_input_divider_reg;
	logic [REG_W-1:0] core_clock_source_reg;
	logic [REG_W-1:0] pll_run_control_reg;
	logic [REG_W-1:0] clock_output_control_reg;
	logic [REG_W-1:0] main_power_gating_reg;
	logic [REG_W-1:0] aux_power_gating_reg;
	logic [REG_W-1:0] core_sleep_control_reg;
	logic [REG_W-1:0] frame_pulse_select_reg;
	logic [REG_W-1:0] core_launch_control_reg;
	logic [REG_W-1:0] core_halt_control_reg;
	logic [REG_W-1:0] program_entry_point_reg;
	logic [REG_W-1:0] chip_restart_control_reg;
	logic [WAIT_CNT_W-1:0] wait_cnt_reg;
	logic [FRAME_CNT_W-1:0] frame_cnt_reg;
	logic [REG_W-1:0] rdata_next;
	dssi_core_t core_reg;
	logic pll_locking;
	logic in_soft_reset;
	logic busy;
	logic wr_ok;
	logic rd_ok;
	logic launch_edge;
	logic pll_start;
	logic frame_tick;
	logic trigger;

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	dssi_spi_entry u_spi (
		.mclk(mclk),
		.nrst(nrst),
		.select_or_addr_pin(select_or_addr_pin),
		.spi_mode(spi_mode)
	);

	dssi_pll_lock #(
		.LOCK_CYCLES(LOCK_CYCLES)
	) u_lock (
		.mclk(mclk),
		.nrst(nrst),
		.start(pll_start),
		.stop(in_soft_reset),
		.locking(pll_locking),
		.locked(pll_locked)
	);

	// ----------------------------------------
	// Access gating
	// ----------------------------------------
	assign in_soft_reset = ~chip_restart_control_reg[BIT_EN];
	assign busy = pll_locking | (wait_cnt_reg != '0);
	assign wr_ok = wr_en & ~busy & (~in_soft_reset | (addr == ADDR_RESTART));
	assign rd_ok = rd_en & ~busy;
	assign pll_start = wr_ok & ~in_soft_reset & (addr == ADDR_PLL_RUN)
		& wdata[BIT_EN];
	assign launch_edge = wr_ok & ~in_soft_reset & (addr == ADDR_LAUNCH)
		& wdata[BIT_EN] & ~core_launch_control_reg[BIT_EN];

	// Wait after leaving soft reset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wait_cnt_reg <= '0;
		end else if (wr_ok && addr == ADDR_RESTART && wdata[BIT_EN]
			&& in_soft_reset) begin
			wait_cnt_reg <= WAIT_CNT_W'(SOFT_WAIT_CYC);
		end else if (wait_cnt_reg != '0) begin
			wait_cnt_reg <= wait_cnt_reg - 1'b1;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			chip_restart_control_reg <= RST_RESTART;
		end else if (wr_ok && addr == ADDR_RESTART) begin
			chip_restart_control_reg <= wdata;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pll_feedback_divider_reg <= RST_PLL_FB_DIV;
			pll_input_divider_reg <= RST_ZERO;
			core_clock_source_reg <= RST_ZERO;
			pll_run_control_reg <= RST_ZERO;
			clock_output_control_reg <= RST_ZERO;
			main_power_gating_reg <= RST_ZERO;
			aux_power_gating_reg <= RST_ZERO;
			core_sleep_control_reg <= RST_ZERO;
			frame_pulse_select_reg <= RST_ZERO;
			core_launch_control_reg <= RST_ZERO;
			core_halt_control_reg <= RST_ZERO;
			program_entry_point_reg <= RST_ZERO;
		end else if (wr_ok && !in_soft_reset) begin
			unique case (addr)
				ADDR_PLL_FB_DIV: pll_feedback_divider_reg <= wdata;
				ADDR_PLL_IN_DIV: pll_input_divider_reg <= wdata;
				ADDR_CORE_CLK_SRC: core_clock_source_reg <= wdata;
				ADDR_PLL_RUN: pll_run_control_reg <= wdata;
				ADDR_CLK_OUT: clock_output_control_reg <= wdata;
				ADDR_MAIN_PWR: main_power_gating_reg <= wdata;
				ADDR_AUX_PWR: aux_power_gating_reg <= wdata;
				ADDR_SLEEP: core_sleep_control_reg <= wdata;
				ADDR_PULSE_SEL: frame_pulse_select_reg <= wdata;
				ADDR_LAUNCH: core_launch_control_reg <= wdata;
				ADDR_HALT: core_halt_control_reg <= wdata;
				ADDR_ENTRY: program_entry_point_reg <= wdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	always_comb begin
		rdata_next = '0;
		unique case (addr)
			ADDR_PLL_FB_DIV: rdata_next = pll_feedback_divider_reg;
			ADDR_PLL_IN_DIV: rdata_next = pll_input_divider_reg;
			ADDR_CORE_CLK_SRC: rdata_next = core_clock_source_reg;
			ADDR_PLL_RUN: rdata_next = pll_run_control_reg;
			ADDR_PLL_LOCK: rdata_next = {15'h0000, pll_locked};
			ADDR_CLK_OUT: rdata_next = clock_output_control_reg;
			ADDR_MAIN_PWR: rdata_next = main_power_gating_reg;
			ADDR_AUX_PWR: rdata_next = aux_power_gating_reg;
			ADDR_SLEEP: rdata_next = core_sleep_control_reg;
			ADDR_PULSE_SEL: rdata_next = frame_pulse_select_reg;
			ADDR_LAUNCH: rdata_next = core_launch_control_reg;
			ADDR_HALT: rdata_next = core_halt_control_reg;
			ADDR_ENTRY: rdata_next = program_entry_point_reg;
			ADDR_RESTART: rdata_next = chip_restart_control_reg;
			default: rdata_next = '0;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata <= '0;
			rd_valid <= 1'b0;
			acc_fail <= 1'b0;
		end else begin
			rd_valid <= rd_ok;
			if (rd_ok) begin
				rdata <= rdata_next;
			end
			acc_fail <= (wr_en | rd_en) & busy;
		end
	end

	// ----------------------------------------
	// Core control
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			core_reg <= CORE_STOPPED;
			core_pc <= '0;
		end else begin
			unique case (core_reg)
				CORE_STOPPED: begin
					if (launch_edge && !core_halt_control_reg[BIT_EN]) begin
						core_reg <= CORE_RUNNING;
						core_pc <= program_entry_point_reg;
					end
				end
				CORE_RUNNING: begin
					if (in_soft_reset || core_halt_control_reg[BIT_EN]) begin
						core_reg <= CORE_STOPPED;
					end
				end
			endcase
		end
	end

	// Internal frame pulse generator
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			frame_cnt_reg <= '0;
		end else if (frame_tick) begin
			frame_cnt_reg <= '0;
		end else begin
			frame_cnt_reg <= frame_cnt_reg + 1'b1;
		end
	end

	assign frame_tick = frame_cnt_reg == FRAME_CNT_W'(FRAME_CYC - 1);
	assign trigger = (frame_pulse_select_reg == PULSE_INTERNAL)
		? frame_tick : ext_frame_pulse;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			core_frame_start <= 1'b0;
			core_running <= 1'b0;
		end else begin
			core_frame_start <= (core_reg == CORE_RUNNING) && trigger
				&& !core_halt_control_reg[BIT_EN];
			core_running <= (core_reg == CORE_RUNNING);
		end
	end

	// ----------------------------------------
	// Configuration outputs
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			soft_reset_active <= 1'b0;
			hibernate <= 1'b0;
			pll_mult <= RST_PLL_FB_DIV;
			pll_prediv <= 4'h1;
			core_clk_from_pll <= 1'b0;
			clkout_en <= 1'b0;
			clkout_rate <= 2'h0;
			main_power <= RST_ZERO;
			aux_power <= RST_ZERO;
		end else begin
			soft_reset_active <= in_soft_reset;
			hibernate <= core_sleep_control_reg[BIT_EN];
			pll_mult <= pll_feedback_divider_reg;
			pll_prediv <= 4'h1 << pll_input_divider_reg[PREDIV_MSB:0];
			core_clk_from_pll <= core_clock_source_reg[BIT_EN];
			clkout_en <= clock_output_control_reg[BIT_EN];
			clkout_rate <=
				clock_output_control_reg[CLKOUT_RATE_MSB:CLKOUT_RATE_LSB];
			main_power <= main_power_gating_reg;
			aux_power <= aux_power_gating_reg;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence halt_write_s;
		wr_ok && !in_soft_reset && addr == ADDR_HALT && wdata[BIT_EN];
	endsequence

	sequence launch_s;
		launch_edge && !core_halt_control_reg[BIT_EN];
	endsequence

	spi_mode_sticky_a: assert property ($fell(spi_mode) == 1'b0)
		else $error("spi mode dropped");
	spi_mode_rise_a: assert property ($rose(spi_mode) |->
		$past(select_or_addr_pin) && !$past(select_or_addr_pin, 2))
		else $error("spi mode without a rising toggle");
	soft_wait_a: assert property (wr_ok && addr == ADDR_RESTART
		&& wdata[BIT_EN] && in_soft_reset |=> busy [*8])
		else $error("access allowed too soon after soft reset");
	halt_stop_a: assert property (halt_write_s |-> ##3 !core_running)
		else $error("core still runs after halt");
	halt_block_a: assert property (core_halt_control_reg[BIT_EN]
		&& core_reg == CORE_STOPPED |=> core_reg == CORE_STOPPED)
		else $error("core started while halted");
	launch_run_a: assert property (launch_s |=> core_reg == CORE_RUNNING
		&& core_pc == $past(program_entry_point_reg))
		else $error("launch edge did not start core at entry");
	prediv_map_a: assert property (pll_input_divider_reg[PREDIV_MSB:0]
		== 2'h2 |=> pll_prediv == 4'h4)
		else $error("input divider 2 not divide by 4");
	lock_fail_a: assert property (pll_locking && wr_en |=> acc_fail)
		else $error("write not refused while locking");
	lock_read_a: assert property (rd_ok && addr == ADDR_PLL_LOCK |=>
		rd_valid && rdata[0] == $past(pll_locked))
		else $error("lock status misread");
	frame_run_a: assert property (core_frame_start |->
		$past(core_reg) == CORE_RUNNING)
		else $error("frame start while core stopped");

endmodule : dssi_startup
`default_nettype wire

// ---- verif/dssi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dssi_host_model
	import dssi_pkg::*;
(
	input wire logic mclk,
	input wire logic [dssi_pkg::REG_W-1:0] rdata,
	input wire logic rd_valid,
	input wire logic acc_fail,
	output var logic select_or_addr_pin,
	output var logic wr_en,
	output var logic rd_en,
	output var logic [dssi_pkg::ADDR_W-1:0] addr,
	output var logic [dssi_pkg::REG_W-1:0] wdata
);
	initial begin
		select_or_addr_pin = 1'b1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 16'h0000;
		wdata = 16'h0000;
	end

	// ----------------------------------------
	// Select pin toggles
	// ----------------------------------------
	task automatic toggle(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge mclk) select_or_addr_pin = 1'b0;
			@(negedge mclk) select_or_addr_pin = 1'b1;
		end
	endtask : toggle

	// ----------------------------------------
	// One register access
	// ----------------------------------------
	task automatic access(input logic w, input logic [15:0] a,
		input logic [15:0] d, output logic f, output logic v,
		output logic [15:0] q);
		@(negedge mclk);
		wr_en = w;
		rd_en = !w;
		addr = a;
		wdata = d;
		@(negedge mclk);
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = ~a;
		wdata = ~d;
		f = acc_fail;
		v = rd_valid;
		@(negedge mclk);
		f = f | acc_fail;
		v = v | rd_valid;
		q = rdata;
	endtask : access
endmodule : dssi_host_model
`default_nettype wire

// ---- verif/test_dssi_startup_init_sequence.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module test_dssi_startup_init_sequence;
	import dssi_pkg::*;
	logic mclk, nrst, pin, wr_en, rd_en, ext_frame_pulse;
	logic [15:0] addr, wdata, rdata, core_pc, pll_mult, main_power, aux_power;
	logic rd_valid, acc_fail, spi_mode, pll_locked, soft_reset_active;
	logic hibernate, core_running, core_frame_start, core_clk_from_pll;
	logic clkout_en;
	logic [1:0] clkout_rate;
	logic [3:0] pll_prediv;
	int failures = 0;
	int compares = 0;

	dssi_startup #(.LOCK_CYCLES(20)) dssi_startup_inst (.mclk(mclk),
		.nrst(nrst), .select_or_addr_pin(pin), .wr_en(wr_en),
		.rd_en(rd_en), .addr(addr), .wdata(wdata),
		.ext_frame_pulse(ext_frame_pulse), .rdata(rdata),
		.rd_valid(rd_valid), .acc_fail(acc_fail), .spi_mode(spi_mode),
		.pll_locked(pll_locked), .soft_reset_active(soft_reset_active),
		.hibernate(hibernate), .core_running(core_running),
		.core_frame_start(core_frame_start), .core_pc(core_pc),
		.pll_mult(pll_mult), .pll_prediv(pll_prediv),
		.core_clk_from_pll(core_clk_from_pll), .clkout_en(clkout_en),
		.clkout_rate(clkout_rate), .main_power(main_power),
		.aux_power(aux_power));

	dssi_host_model dssi_host_model_inst (.mclk(mclk), .rdata(rdata),
		.rd_valid(rd_valid), .acc_fail(acc_fail),
		.select_or_addr_pin(pin), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wdata(wdata));

	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic results();
		$display("Counts: compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic wr(input logic [15:0] a, input logic [15:0] d,
		input logic ef);
		logic f, v;
		logic [15:0] q;
		dssi_host_model_inst.access(1'b1, a, d, f, v, q);
		`CHK(f, ef)
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		logic f, v;
		logic [15:0] q;
		dssi_host_model_inst.access(1'b0, a, 16'h0000, f, v, q);
		`CHK(v, 1'b1)
		`CHK(q, e)
	endtask : rd

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		`CHK(pll_mult, 16'h0060)
		`CHK(pll_prediv, 4'h1)
		rd(ADDR_PLL_FB_DIV, 16'h0060);
		rd(16'hF0FF, 16'h0000);
	endtask : t_reset

	task automatic t_spi();
		dssi_host_model_inst.toggle(2);
		cyc(3);
		`CHK(spi_mode, 1'b0)
		dssi_host_model_inst.toggle(1);
		cyc(2);
		`CHK(spi_mode, 1'b1)
	endtask : t_spi

	task automatic t_soft();
		wr(ADDR_RESTART, 16'h0000, 1'b0);
		cyc(2);
		`CHK(soft_reset_active, 1'b1)
		wr(ADDR_SLEEP, 16'h0001, 1'b0);
		wr(ADDR_RESTART, 16'h0001, 1'b0);
		wr(ADDR_SLEEP, 16'h0001, 1'b1);
		cyc(2);
		`CHK(soft_reset_active, 1'b0)
		`CHK(hibernate, 1'b0)
		cyc(SOFT_WAIT_CYC);
		wr(ADDR_SLEEP, 16'h0000, 1'b0);
		wr(ADDR_SLEEP, 16'h0001, 1'b0);
		cyc(2);
		`CHK(hibernate, 1'b1)
		cyc(FRAME_CYC);
	endtask : t_soft

	task automatic t_config();
		wr(ADDR_HALT, 16'h0001, 1'b0);
		wr(ADDR_PLL_FB_DIV, 16'h0048, 1'b0);
		cyc(2);
		`CHK(pll_mult, 16'h0048)
		wr(ADDR_PLL_FB_DIV, 16'h0060, 1'b0);
		for (int i = 3; i >= 0; i--) begin
			wr(ADDR_PLL_IN_DIV, 16'(i), 1'b0);
			cyc(2);
			`CHK(pll_prediv, 4'(1 << i))
		end
		wr(ADDR_PLL_IN_DIV, 16'h0002, 1'b0);
		wr(ADDR_CORE_CLK_SRC, 16'h0001, 1'b0);
		wr(ADDR_CLK_OUT, 16'h0005, 1'b0);
		wr(ADDR_MAIN_PWR, 16'h4FFF, 1'b0);
		wr(ADDR_AUX_PWR, 16'hFFFF, 1'b0);
		wr(ADDR_AUX_PWR, 16'h0000, 1'b0);
		cyc(2);
		`CHK(pll_prediv, 4'h4)
		`CHK(core_clk_from_pll, 1'b1)
		`CHK(clkout_en, 1'b1)
		`CHK(clkout_rate, 2'h2)
		`CHK(main_power, 16'h4FFF)
		`CHK(aux_power, 16'h0000)
		rd(ADDR_MAIN_PWR, 16'h4FFF);
	endtask : t_config

	task automatic t_pll();
		logic f, v;
		logic [15:0] q;
		wr(ADDR_PLL_RUN, 16'h0001, 1'b0);
		wr(ADDR_ENTRY, 16'h0077, 1'b1);
		for (int i = 0; i < 100; i++) begin
			dssi_host_model_inst.access(1'b0, ADDR_PLL_LOCK, 16'h0000,
				f, v, q);
			if (v === 1'b1 && q[0] === 1'b1) break;
			if (i == 99) begin
				failures++;
				results();
			end
		end
		`CHK(q, 16'h0001)
		cyc(1);
		`CHK(pll_locked, 1'b1)
		rd(ADDR_ENTRY, 16'h0000);
	endtask : t_pll

	task automatic t_core();
		logic seen;
		seen = 1'b0;
		wr(16'hC000, 16'h0000, 1'b0);
		wr(16'h0000, 16'h0000, 1'b0);
		wr(16'h6000, 16'h0000, 1'b0);
		wr(ADDR_ENTRY, 16'h0123, 1'b0);
		wr(ADDR_PULSE_SEL, PULSE_INTERNAL, 1'b0);
		wr(ADDR_LAUNCH, 16'h0000, 1'b0);
		wr(ADDR_LAUNCH, 16'h0001, 1'b0);
		wr(ADDR_HALT, 16'h0000, 1'b0);
		cyc(3);
		`CHK(core_running, 1'b0)
		wr(ADDR_LAUNCH, 16'h0000, 1'b0);
		wr(ADDR_LAUNCH, 16'h0001, 1'b0);
		cyc(3);
		`CHK(core_running, 1'b1)
		`CHK(core_pc, 16'h0123)
		for (int i = 0; i < 2200 && !seen; i++) begin
			cyc(1);
			seen = (core_frame_start === 1'b1);
		end
		`CHK(seen, 1'b1)
		wr(ADDR_PULSE_SEL, 16'h0000, 1'b0);
		@(negedge mclk) ext_frame_pulse = 1'b1;
		@(negedge mclk) ext_frame_pulse = 1'b0;
		`CHK(core_frame_start, 1'b1)
		wr(ADDR_HALT, 16'h0001, 1'b0);
		cyc(1);
		`CHK(core_running, 1'b0)
		cyc(5000);
		wr(ADDR_SLEEP, 16'h0000, 1'b0);
		cyc(2);
		`CHK(hibernate, 1'b0)
	endtask : t_core

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		ext_frame_pulse = 1'b0;
		repeat (20) @(negedge mclk);
		nrst = 1'b1;
		t_reset();
		t_spi();
		t_soft();
		t_config();
		t_pll();
		t_core();
		results();
	end
endmodule : test_dssi_startup_init_sequence
`default_nettype wire
